// >>> hw/ssw_consts.svh
// Purpose: Constants of the switch error, burst and reset register block
// Assumes: 16-bit commands, 24 bits with the check byte appended
// Notes: Functional notes follow
`ifndef SSW_CONSTS_SVH
`define SSW_CONSTS_SVH
`define SSW_ADDR_SWITCH 7'h01
`define SSW_ADDR_CFG 7'h02
`define SSW_ADDR_FLAGS 7'h03
`define SSW_ADDR_BURST 7'h05
`define SSW_ADDR_KEY 7'h0b
`define SSW_RST_ZERO 8'h00
`define SSW_RST_CFG 8'h06
`define SSW_CLEAR_WORD 16'h6ca9
`define SSW_KEY_ARM 8'ha3
`define SSW_KEY_FIRE 8'h05
`define SSW_LEN_PLAIN 5'h10
`define SSW_LEN_CRC 5'h18
`define SSW_DATA_START 5'h08
`define SSW_CRC_POLY 8'h07
`define SSW_FLAG_CRC 0
`define SSW_FLAG_SCLK 1
`define SSW_FLAG_RW 2
`define SSW_BURST_BIT 0
`define SSW_PIN_RST 3'h1
`endif

// >>> hw/ssw_pin_if.sv
// Purpose: Carries conditioned serial pin events to the register core
// Assumes: Producer runs on sys_clk
// Notes: Edges are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface ssw_pin_if;
  logic cs_act;
  logic sclk_rise;
  logic sclk_fall;
  logic mosi;
  modport sync (output cs_act, output sclk_rise, output sclk_fall,
    output mosi);
  modport core (input cs_act, input sclk_rise, input sclk_fall,
    input mosi);
endinterface
`default_nettype wire

// >>> hw/ssw_pin_sync.sv
// Purpose: Three-stage pin conditioning and serial clock edge finding
// Assumes: Pins are asynchronous to sys_clk
// Notes: A level changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
`include "ssw_consts.svh"
module ssw_pin_sync
  import ssw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  // Conditioned events
  ssw_pin_if.sync pins
);
  logic [2:0] raw;
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;
  logic [2:0] lvl_ff;
  logic [2:0] prv_ff;
  // Idle pin levels: select high, clock and data low
  localparam logic [2:0] pin_idle = `SSW_PIN_RST;

  assign raw = {sdi, sclk, cs_n};

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          s1_ff[i] <= pin_idle[i];
          s2_ff[i] <= pin_idle[i];
          s3_ff[i] <= pin_idle[i];
          lvl_ff[i] <= pin_idle[i];
          prv_ff[i] <= pin_idle[i];
        end else begin
          s1_ff[i] <= raw[i];
          s2_ff[i] <= s1_ff[i];
          s3_ff[i] <= s2_ff[i];
          // Agreement filter rejects a single metastable sample
          if (s2_ff[i] == s3_ff[i]) begin
            lvl_ff[i] <= s3_ff[i];
          end
          prv_ff[i] <= lvl_ff[i];
        end
      end
    end
  endgenerate

  assign pins.cs_act = ~lvl_ff[0];
  assign pins.sclk_rise = lvl_ff[1] & ~prv_ff[1];
  assign pins.sclk_fall = ~lvl_ff[1] & prv_ff[1];
  assign pins.mosi = lvl_ff[2];
endmodule // ssw_pin_sync
`default_nettype wire

// >>> hw/ssw_pkg.sv
// Purpose: Shared types of the switch register block
// Assumes: Constants come from ssw_consts.svh
// Notes: Action enum drives the command decode
package ssw_pkg;
  typedef logic [7:0] ssw_byte_t;
  typedef enum logic [2:0] {
    SSW_ACT_WRITE,
    SSW_ACT_READ,
    SSW_ACT_CLEAR,
    SSW_ACT_CRC_BAD
  } ssw_act_e;
endpackage

// >>> hw/ssw_regs.sv
// Purpose: Serial command decode with error flags, burst and soft reset
// Assumes: Serial mode 0/3, MSB first, bit 15 set means read
// Notes: Read data leaves on sdo during the low command byte
`timescale 1ns/1ps
`default_nettype none
`include "ssw_consts.svh"
module ssw_regs
  import ssw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Switch drive
  output logic [3:0] switch_en
);
  ssw_pin_if pins ();
  ssw_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi),
    .pins(pins)
  );

  ////////////////////////////////////////////////////////////////////////
  // Frame assembly
  logic cs_prev_ff, cs_end, boundary, done_ff, more_ff, cnt_ok, pend_ff;
  logic crc_mode_ff, crc_bad_ff, exec, soft_rst, armed_ff, ran_ff;
  logic [23:0] shift_ff, nxt_shift;
  logic [4:0] bit_cnt_ff, frame_len;
  logic [7:0] crc_ff, crc_base, nxt_crc;
  logic [15:0] word_ff;
  logic [2:0] flags_ff;
  ssw_byte_t cfg_ff, burst_ff, key_ff;

  assign cs_end = cs_prev_ff & ~pins.cs_act;
  // Frame length follows the check byte enable
  assign frame_len = cfg_ff[`SSW_FLAG_CRC] ? `SSW_LEN_CRC
    : `SSW_LEN_PLAIN;
  assign boundary = pins.cs_act & pins.sclk_rise
    & (bit_cnt_ff + 5'h01 == frame_len);
  assign nxt_shift = {shift_ff[22:0], pins.mosi};
  assign crc_base = (bit_cnt_ff == 5'h00) ? `SSW_RST_ZERO : crc_ff;
  assign nxt_crc = {crc_base[6:0], 1'b0}
    ^ ((crc_base[7] ^ pins.mosi) ? `SSW_CRC_POLY : `SSW_RST_ZERO);
  // Non-burst frames must be exactly one command long
  assign cnt_ok = done_ff & (bit_cnt_ff == 5'h00)
    & (burst_ff[`SSW_BURST_BIT] | ~more_ff);

  always_ff @(posedge sys_clk) begin
    if (rst || !pins.cs_act) begin
      bit_cnt_ff <= 5'h00;
      shift_ff <= 24'h000000;
      crc_ff <= `SSW_RST_ZERO;
      done_ff <= 1'b0;
      more_ff <= 1'b0;
    end else if (pins.sclk_rise) begin
      shift_ff <= nxt_shift;
      bit_cnt_ff <= boundary ? 5'h00 : bit_cnt_ff + 5'h01;
      if (bit_cnt_ff < `SSW_LEN_PLAIN) begin
        crc_ff <= nxt_crc;
      end
      if (boundary) begin
        done_ff <= 1'b1;
        more_ff <= done_ff;
      end
    end
  end

  // Command capture; the check byte trails the 16-bit word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_prev_ff <= 1'b0;
      ran_ff <= 1'b0;
      pend_ff <= 1'b0;
      word_ff <= 16'h0000;
      crc_mode_ff <= 1'b0;
      crc_bad_ff <= 1'b0;
    end else begin
      cs_prev_ff <= pins.cs_act;
      // A word acts once even if burst mode is left mid-selection
      ran_ff <= boundary ? 1'b0 : (ran_ff | exec);
      pend_ff <= boundary;
      if (boundary) begin
        crc_mode_ff <= cfg_ff[`SSW_FLAG_CRC];
        word_ff <= cfg_ff[`SSW_FLAG_CRC] ? nxt_shift[23:8]
          : nxt_shift[15:0];
        crc_bad_ff <= nxt_shift[7:0] != crc_ff;
      end
    end
  end

  // Burst acts per command, otherwise only on a well-counted frame
  assign exec = burst_ff[`SSW_BURST_BIT] ? pend_ff
    : (cs_end & cnt_ok & ~ran_ff);

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  ssw_act_e act;
  logic [6:0] addr;
  logic rd_ok, wr_ok, set_rw, set_crc, set_sclk, clr_flags, wr_en;
  assign addr = word_ff[14:8];
  always_comb begin
    if (crc_mode_ff && crc_bad_ff) begin
      act = SSW_ACT_CRC_BAD;
    end else if (word_ff == `SSW_CLEAR_WORD) begin
      act = SSW_ACT_CLEAR;
    end else if (word_ff[15]) begin
      act = SSW_ACT_READ;
    end else begin
      act = SSW_ACT_WRITE;
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    if (addr == `SSW_ADDR_FLAGS) begin
      wr_ok = 1'b0;
    end else if (addr != `SSW_ADDR_SWITCH && addr != `SSW_ADDR_CFG
        && addr != `SSW_ADDR_BURST && addr != `SSW_ADDR_KEY) begin
      rd_ok = 1'b0;
      wr_ok = 1'b0;
    end
  end

  always_comb begin
    set_rw = 1'b0;
    set_crc = 1'b0;
    wr_en = 1'b0;
    clr_flags = 1'b0;
    if (exec) begin
      case (act)
        SSW_ACT_CRC_BAD: set_crc = ~word_ff[15];
        SSW_ACT_CLEAR: clr_flags = 1'b1;
        SSW_ACT_READ: set_rw = ~rd_ok;
        default: begin
          set_rw = ~wr_ok;
          wr_en = wr_ok;
        end
      endcase
    end
    set_rw = set_rw & cfg_ff[`SSW_FLAG_RW];
    set_crc = set_crc & cfg_ff[`SSW_FLAG_CRC];
  end

  assign set_sclk = cs_end & ~cnt_ok & cfg_ff[`SSW_FLAG_SCLK];

  ////////////////////////////////////////////////////////////////////////
  // Registers
  assign soft_rst = wr_en & (addr == `SSW_ADDR_KEY) & armed_ff
    & (word_ff[7:0] == `SSW_KEY_FIRE);

  // Key sequence; anything else written breaks it
  always_ff @(posedge sys_clk) begin
    if (rst || soft_rst) begin
      armed_ff <= 1'b0;
    end else if (wr_en) begin
      armed_ff <= (addr == `SSW_ADDR_KEY)
        & (word_ff[7:0] == `SSW_KEY_ARM);
    end
  end

  // Soft reset restores every register default
  always_ff @(posedge sys_clk) begin
    if (rst || soft_rst) begin
      cfg_ff <= `SSW_RST_CFG;
      burst_ff <= `SSW_RST_ZERO;
      key_ff <= `SSW_RST_ZERO;
      switch_en <= 4'h0;
    end else if (wr_en) begin
      if (addr == `SSW_ADDR_CFG) begin
        cfg_ff <= {5'h00, word_ff[2:0]};
      end else if (addr == `SSW_ADDR_BURST) begin
        burst_ff <= {7'h00, word_ff[0]};
      end else if (addr == `SSW_ADDR_KEY) begin
        key_ff <= word_ff[7:0];
      end else if (addr == `SSW_ADDR_SWITCH) begin
        switch_en <= word_ff[3:0];
      end
    end
  end

  // Sticky flags; a new event outranks a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (rst || soft_rst) begin
      flags_ff <= 3'h0;
    end else begin
      flags_ff <= (clr_flags ? 3'h0 : flags_ff)
        | {set_rw, set_sclk, set_crc};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read return
  ssw_byte_t rd_data, out_ff;
  logic [6:0] rd_addr;
  assign rd_addr = shift_ff[6:0];

  always_comb begin
    if (rd_addr == `SSW_ADDR_FLAGS) begin
      rd_data = {5'h00, flags_ff};
    end else if (rd_addr == `SSW_ADDR_CFG) begin
      rd_data = cfg_ff;
    end else if (rd_addr == `SSW_ADDR_BURST) begin
      rd_data = burst_ff;
    end else if (rd_addr == `SSW_ADDR_KEY) begin
      rd_data = key_ff;
    end else if (rd_addr == `SSW_ADDR_SWITCH) begin
      rd_data = {4'h0, switch_en};
    end else begin
      rd_data = `SSW_RST_ZERO;
    end
  end

  // Data changes on falling edges so the controller samples it rising
  always_ff @(posedge sys_clk) begin
    if (rst || !pins.cs_act) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      out_ff <= `SSW_RST_ZERO;
    end else begin
      sdo_oe <= 1'b1;
      if (pins.sclk_fall) begin
        if (bit_cnt_ff == `SSW_DATA_START) begin
          sdo <= rd_data[7];
          out_ff <= {rd_data[6:0], 1'b0};
        end else if (bit_cnt_ff > `SSW_DATA_START
            && bit_cnt_ff < `SSW_LEN_PLAIN) begin
          sdo <= out_ff[7];
          out_ff <= {out_ff[6:0], 1'b0};
        end else begin
          sdo <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_flag_upper_zero: assert property (
    (rd_addr == `SSW_ADDR_FLAGS) |-> (rd_data[7:3] == 5'h00))
    else $error("flag register upper bits not zero");
  a_clear_all_flags: assert property (
    (exec && act == SSW_ACT_CLEAR && !soft_rst)
      |=> (flags_ff == {$past(set_rw), $past(set_sclk), $past(set_crc)}))
    else $error("clear command left flags set");
  a_clear_no_rw: assert property (
    (exec && act == SSW_ACT_CLEAR) |-> !set_rw)
    else $error("clear command raised address flag");
  a_crc_blocks_clear: assert property (
    (exec && crc_mode_ff && crc_bad_ff) |-> !clr_flags)
    else $error("clear acted on bad check byte");
  a_rw_bad_read: assert property (
    (exec && act == SSW_ACT_READ && !rd_ok && cfg_ff[`SSW_FLAG_RW])
      |=> flags_ff[`SSW_FLAG_RW])
    else $error("bad read address not flagged");
  a_rw_ro_write: assert property (
    (exec && act == SSW_ACT_WRITE && addr == `SSW_ADDR_FLAGS
      && cfg_ff[`SSW_FLAG_RW]) |=> flags_ff[`SSW_FLAG_RW])
    else $error("write to read-only register not flagged");
  a_sclk_count: assert property (
    (cs_end && !cnt_ok && cfg_ff[`SSW_FLAG_SCLK] && !soft_rst)
      |=> flags_ff[`SSW_FLAG_SCLK])
    else $error("clock count error not flagged");
  a_crc_write_flag: assert property (
    (exec && act == SSW_ACT_CRC_BAD && !word_ff[15]
      && cfg_ff[`SSW_FLAG_CRC]) |=> flags_ff[`SSW_FLAG_CRC])
    else $error("write check byte error not flagged");
  a_flags_sticky: assert property (
    (|($past(flags_ff) & ~flags_ff))
      |-> ($past(clr_flags) || $past(soft_rst) || $past(rst)))
    else $error("flag dropped without clear");
  a_soft_defaults: assert property (
    soft_rst |=> (cfg_ff == `SSW_RST_CFG && burst_ff == `SSW_RST_ZERO
      && flags_ff == 3'h0 && switch_en == 4'h0))
    else $error("soft reset missed a default");
  a_key_abort: assert property (
    (wr_en && addr == `SSW_ADDR_KEY && word_ff[7:0] != `SSW_KEY_ARM)
      |=> !armed_ff)
    else $error("key sequence not abandoned");

  c_clear_cmd: cover property (exec && act == SSW_ACT_CLEAR);
  c_soft_reset: cover property (soft_rst);
  c_burst_two: cover property (pend_ff && more_ff && burst_ff[0]);
  c_crc_bad: cover property (exec && act == SSW_ACT_CRC_BAD);
endmodule // ssw_regs
`default_nettype wire

// >>> tb/spi_switch_error_burst_reset_regs_bench.sv
// Purpose: Self-checking bench of the switch register block
// Assumes: Controller model drives cs_n, sclk and sdi
// Notes: Flags are cleared after each error case outside the check byte test to isolate cases
`timescale 1ns/1ps
`default_nettype none
`include "ssw_consts.svh"
module spi_switch_error_burst_reset_regs_bench
  import ssw_pkg::*;
;
  logic sys_clk;
  logic rst;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic [3:0] switch_en;
  int miscompares;
  int tests_run;
  int cycles;
  int seed;
  int cnt[3] = '{0, 15, 17};
  ssw_byte_t rd;
  ssw_byte_t v;
  logic [15:0] w;
  ssw_regs i_ssw_regs (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .switch_en(switch_en));
  ssw_spi_host i_ssw_spi_host (.sys_clk(sys_clk), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////
  function automatic ssw_byte_t exp_sw(input ssw_byte_t d);
    return {4'h0, d[3:0]};
  endfunction
  task automatic chk(input string name, input logic [7:0] exp,
      input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic sw(input ssw_byte_t exp);
    chk("switch_en", exp, {4'h0, switch_en});
  endtask
  task automatic wr(input logic [6:0] a, input ssw_byte_t d);
    ssw_byte_t r;
    i_ssw_spi_host.cmd({1'b0, a, d}, r);
  endtask
  task automatic rdchk(input logic [6:0] a, input ssw_byte_t exp);
    ssw_byte_t r;
    i_ssw_spi_host.cmd({1'b1, a, 8'h00}, r);
    chk($sformatf("register %h", a), exp, r);
  endtask
  task automatic clr();
    ssw_byte_t r;
    i_ssw_spi_host.cmd(`SSW_CLEAR_WORD, r);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 26k cycles the frames need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      $display("ERROR timeout expected done seen hang");
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    seed = 77;
    rst = 1'b1;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    rdchk(`SSW_ADDR_CFG, `SSW_RST_CFG);
    rdchk(`SSW_ADDR_FLAGS, 8'h00);
    rdchk(`SSW_ADDR_BURST, 8'h00);
    $display("test reset values done");
    wr(`SSW_ADDR_FLAGS, 8'hff);
    rdchk(`SSW_ADDR_FLAGS, 8'h04);
    rdchk(`SSW_ADDR_FLAGS, 8'h04);
    clr();
    rdchk(`SSW_ADDR_FLAGS, 8'h00);
    i_ssw_spi_host.cmd(16'h8400, rd);
    rdchk(`SSW_ADDR_FLAGS, 8'h04);
    clr();
    wr(7'h7e, 8'h01);
    rdchk(`SSW_ADDR_FLAGS, 8'h04);
    clr();
    wr(`SSW_ADDR_CFG, 8'h00);
    wr(`SSW_ADDR_FLAGS, 8'h01);
    rdchk(`SSW_ADDR_FLAGS, 8'h00);
    wr(`SSW_ADDR_CFG, `SSW_RST_CFG);
    $display("test address errors done");
    for (int i = 0; i < 3; i++) begin
      i_ssw_spi_host.raw(48'h010f, cnt[i], rd);
      rdchk(`SSW_ADDR_FLAGS, 8'h02);
      sw(8'h00);
      clr();
    end
    $display("test clock count done");
    repeat (6) begin
      v = 8'($random(seed));
      wr(`SSW_ADDR_SWITCH, v);
      rdchk(`SSW_ADDR_SWITCH, exp_sw(v));
      sw(exp_sw(v));
    end
    $display("test random writes done");
    wr(`SSW_ADDR_BURST, 8'h01);
    rdchk(`SSW_ADDR_BURST, 8'h01);
    i_ssw_spi_host.raw(48'h0103_0105, 32, rd);
    sw(8'h05);
    rdchk(`SSW_ADDR_FLAGS, 8'h00);
    i_ssw_spi_host.raw(48'h0109_01, 24, rd);
    sw(8'h09);
    rdchk(`SSW_ADDR_FLAGS, 8'h02);
    clr();
    wr(`SSW_ADDR_BURST, 8'h00);
    i_ssw_spi_host.raw(48'h0103_0106, 32, rd);
    rdchk(`SSW_ADDR_FLAGS, 8'h02);
    sw(8'h09);
    clr();
    $display("test burst done");
    wr(`SSW_ADDR_CFG, 8'h07);
    i_ssw_spi_host.crc_on = 1'b1;
    wr(`SSW_ADDR_SWITCH, 8'h0c);
    sw(8'h0c);
    w = 16'h0103;
    i_ssw_spi_host.raw({24'h0, w, ~i_ssw_spi_host.crc8(w)}, 24, rd);
    sw(8'h0c);
    rdchk(`SSW_ADDR_FLAGS, 8'h01);
    wr(`SSW_ADDR_FLAGS, 8'h00);
    w = `SSW_CLEAR_WORD;
    i_ssw_spi_host.raw({24'h0, w, ~i_ssw_spi_host.crc8(w)}, 24, rd);
    rdchk(`SSW_ADDR_FLAGS, 8'h05);
    clr();
    rdchk(`SSW_ADDR_FLAGS, 8'h00);
    w = 16'h8100;
    i_ssw_spi_host.raw({24'h0, w, ~i_ssw_spi_host.crc8(w)}, 24, rd);
    rdchk(`SSW_ADDR_FLAGS, 8'h00);
    i_ssw_spi_host.raw(48'h0103, 16, rd);
    rdchk(`SSW_ADDR_FLAGS, 8'h02);
    wr(`SSW_ADDR_CFG, `SSW_RST_CFG);
    i_ssw_spi_host.crc_on = 1'b0;
    $display("test check byte done");
    wr(`SSW_ADDR_SWITCH, 8'h0f);
    wr(`SSW_ADDR_BURST, 8'h01);
    wr(`SSW_ADDR_FLAGS, 8'h00);
    wr(`SSW_ADDR_CFG, 8'h02);
    wr(`SSW_ADDR_KEY, `SSW_KEY_ARM);
    wr(`SSW_ADDR_KEY, 8'h11);
    wr(`SSW_ADDR_KEY, `SSW_KEY_FIRE);
    sw(8'h0f);
    wr(`SSW_ADDR_KEY, `SSW_KEY_ARM);
    wr(`SSW_ADDR_KEY, `SSW_KEY_FIRE);
    sw(8'h00);
    rdchk(`SSW_ADDR_BURST, 8'h00);
    rdchk(`SSW_ADDR_FLAGS, 8'h00);
    rdchk(`SSW_ADDR_KEY, 8'h00);
    rdchk(`SSW_ADDR_CFG, `SSW_RST_CFG);
    $display("test soft reset done");
    results();
  end
endmodule // spi_switch_error_burst_reset_regs_bench
`default_nettype wire

// >>> tb/ssw_spi_host.sv
// Purpose: Serial bus controller model for the switch register block
// Assumes: Mode 0, 80 ns serial clock, MSB first, starts on a falling edge
// Notes: Data line flips between frames so a stale bit never looks valid
`timescale 1ns/1ps
`default_nettype none
`include "ssw_consts.svh"
module ssw_spi_host
  import ssw_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Pins
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic crc_on;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    crc_on = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  function automatic ssw_byte_t crc8(input logic [15:0] w);
    ssw_byte_t c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? `SSW_CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  ////////////////////////////////////////////////////////////////////
  // Clock rests low outside frames; cs_n held over every bit
  task automatic raw(input logic [47:0] v, input int n,
      output ssw_byte_t rd);
    rd = 8'h00;
    @(negedge sys_clk);
    cs_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = v[i];
      #40;
      if (n - 1 - i >= 8 && n - 1 - i < 16) begin
        rd = {rd[6:0], sdo_oe ? sdo : 1'bx};
      end
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
    end
    #40;
    cs_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic cmd(input logic [15:0] w, output ssw_byte_t rd);
    if (crc_on) begin
      raw({24'h0, w, crc8(w)}, 24, rd);
    end else begin
      raw({32'h0, w}, 16, rd);
    end
  endtask
endmodule // ssw_spi_host
`default_nettype wire
